/* rtl/mpi_top.v */
// front panel, menu and input processing logic of the panel meter
//
// Contract
// - select press in display mode advances to next enabled display
// - with scrolling on, displays advance every four seconds
// - program mode entered after select held two seconds
// - entry refused when security code nonzero or lock input active
// - module level alternates prompt and module; reset steps, select enters
// - parameter alternates name and value; reset cycles; select stores, advances
// - reset opens numeric edit at rightmost digit; presses and hold increment
// - short select moves digit; held select stores value and advances
// - select at exit prompt commits settings and returns to display
// - signed offset added to reading, rewritten by zero, inert at zero
// - filter weights new input 1, 1/4, 1/8 or 1/16 by level
// - filter bypassed while change exceeds band, re-engaged below it
// - band zero keeps the filter always engaged
// - two point linear scaling, extrapolated beyond the points
// - live style: reset tracks measured input, select latches it
// - zero and reset act on edge; reset loads captures with reading
// - display hold freezes the display only while input active
// - edge functions act once: select display, colour toggle; intensity stays at the maximum that reset loads
// - print and reset requests print, then briefly resets values
// - user input can reset setpoint 1, setpoint 2 or both
// - annunciators lit while their setpoint output is active
// - scroll parameter offered only when min or max display enabled
`timescale 1ns/1ps
`include "mpi_regs.vh"

module mpi_top #(
   parameter DEB_CYC  = `MPI_DEB_MS * `MPI_CLK_KHZ,
   parameter HOLD_CYC = `MPI_HOLD_MS * `MPI_CLK_KHZ,
   parameter RPT_CYC  = `MPI_RPT_MS * `MPI_CLK_KHZ,
   parameter ALT_CYC  = `MPI_ALT_MS * `MPI_CLK_KHZ,
   parameter SCRL_CYC = `MPI_SCRL_MS * `MPI_CLK_KHZ,
   parameter CW       = 32
)(
   // clock and reset
   input  wire               clk_sys,
   input  wire               rst_n,
   // operator keys and user input
   input  wire               key_sel,
   input  wire               key_rst,
   input  wire               usr_in_n,
   // measurement and setpoint states
   input  wire        [15:0] meas_in,
   input  wire               meas_valid,
   input  wire               sp1_active,
   input  wire               sp2_active,
   // register port
   input  wire        [3:0]  reg_addr,
   input  wire        [31:0] reg_wdata,
   input  wire               reg_wr,
   input  wire               reg_rd,
   output reg         [31:0] reg_rdata,
   // display and menu
   output reg signed  [17:0] disp_out,
   output reg         [1:0]  disp_sel,
   output reg         [2:0]  menu_state,
   output reg                mod_idx,
   output reg         [3:0]  par_idx,
   output reg                show_value,
   output reg         [2:0]  edit_digit,
   output reg signed  [17:0] work_val,
   output reg                annun1,
   output reg                annun2,
   output reg         [2:0]  intensity,
   output reg                color_green,
   // requests to the rest of the meter
   output reg                nv_commit,
   output reg                print_req,
   output reg                sp1_reset,
   output reg                sp2_reset
);

localparam S_DISP = 3'h0;
localparam S_MOD  = 3'h1;
localparam S_PAR  = 3'h2;
localparam S_EDIT = 3'h3;
localparam S_LIVE = 3'h4;

////////////////////////////////////////////////////////////////////////
// helpers

function [19:0] to_bcd;
   input [16:0] v;
   integer i, j;
   reg [19:0] b;
   begin
      b = 20'h0;
      for (i = 16; i >= 0; i = i - 1)
      begin
         for (j = 0; j < 5; j = j + 1)
            if (b[j*4 +: 4] > 4'h4)
               b[j*4 +: 4] = b[j*4 +: 4] + 4'h3;
         b = {b[18:0], v[i]};
      end
      to_bcd = b;
   end
endfunction

function [17:0] from_bcd;
   input [19:0] b;
   integer i;
   reg [17:0] v;
   begin
      v = 18'h0;
      for (i = 4; i >= 0; i = i - 1)
         v = v * 18'hA + {14'h0, b[i*4 +: 4]};
      from_bcd = v;
   end
endfunction

function [1:0] next_disp;
   input [1:0] cur;
   input       min_en;
   input       max_en;
   begin
      case (cur)
         `MPI_DS_INP: next_disp = max_en ? `MPI_DS_MAX : (min_en ? `MPI_DS_MIN : `MPI_DS_INP);
         `MPI_DS_MAX: next_disp = min_en ? `MPI_DS_MIN : `MPI_DS_INP;
         default:     next_disp = `MPI_DS_INP;
      endcase
   end
endfunction

function is_num;
   input [3:0] p;
   begin
      is_num = (p == `MPI_P_BAND) || (p == `MPI_P_OFS) || (p == `MPI_P_IN1) ||
               (p == `MPI_P_DSP1) || (p == `MPI_P_IN2) || (p == `MPI_P_DSP2);
   end
endfunction

function [17:0] choice_max;
   input [3:0] p;
   begin
      case (p)
         `MPI_P_FILT: choice_max = `MPI_MAX_FILT;
         `MPI_P_UFN:  choice_max = `MPI_MAX_UFN;
         `MPI_P_UASN: choice_max = `MPI_MAX_UASN;
         default:     choice_max = `MPI_MAX_BIN;
      endcase
   end
endfunction

////////////////////////////////////////////////////////////////////////
// key and user input conditioning

reg [2:0]    sy1;
reg [2:0]    sy2;
reg [2:0]    deb;
reg [2:0]    deb_q;
reg [CW-1:0] dcnt [0:2];
integer      k;

always @(posedge clk_sys or negedge rst_n)
begin
   if (!rst_n)
   begin
      sy1   <= 3'h0;
      sy2   <= 3'h0;
      deb   <= 3'h0;
      deb_q <= 3'h0;
      for (k = 0; k < 3; k = k + 1)
         dcnt[k] <= {CW{1'b0}};
   end
   else
   begin
      sy1   <= {~usr_in_n, key_rst, key_sel};
      sy2   <= sy1;
      deb_q <= deb;
      for (k = 0; k < 3; k = k + 1)
         if (sy2[k] == deb[k])
            dcnt[k] <= {CW{1'b0}};
         else if (dcnt[k] == DEB_CYC - 1)
         begin
            deb[k]  <= sy2[k];
            dcnt[k] <= {CW{1'b0}};
         end
         else
            dcnt[k] <= dcnt[k] + 1'b1;
   end
end

wire [2:0] rise = deb & ~deb_q;
wire [2:0] fall = ~deb & deb_q;
wire       usr_on = deb[2];

////////////////////////////////////////////////////////////////////////
// hold, repeat, alternation and scroll timers

reg [CW-1:0] sel_cnt;
reg [CW-1:0] rst_cnt;
reg [CW-1:0] alt_cnt;
reg [CW-1:0] scr_cnt;
reg          sel_long;

wire sel_hold = deb[0] && (sel_cnt == HOLD_CYC - 1);
wire rst_rpt  = deb[1] && (rst_cnt == RPT_CYC - 1);

////////////////////////////////////////////////////////////////////////
// parameters, control and measurement

reg signed [17:0] prm [0:`MPI_NPAR-1];
reg        [31:0] ctrl;
reg signed [17:0] filt;
reg signed [17:0] min_cap;
reg signed [17:0] max_cap;
reg        [19:0] work_bcd;
reg               work_neg;
reg               pr_pend;

wire       min_en  = ctrl[`MPI_C_MINEN];
wire       max_en  = ctrl[`MPI_C_MAXEN];
wire [3:0] ufn     = prm[`MPI_P_UFN][3:0];
wire [1:0] uasn    = prm[`MPI_P_UASN][1:0];
wire       scr_ok  = min_en | max_en;
// lock by code or lock input
wire       locked  = (ctrl[`MPI_C_SEC_HI:`MPI_C_SEC_LO] != 10'h0) ||
                     ((ufn == `MPI_UF_PLOC) && usr_on);

// two point line through both points
wire signed [18:0] dx   = {3'h0, meas_in} - prm[`MPI_P_IN1];
wire signed [18:0] dy   = prm[`MPI_P_DSP2] - prm[`MPI_P_DSP1];
wire signed [18:0] den  = prm[`MPI_P_IN2] - prm[`MPI_P_IN1];
wire signed [37:0] num  = dx * dy;
wire signed [37:0] quot = (den == 19'sh0) ? 38'sh0 : num / den;
wire signed [17:0] scaled = prm[`MPI_P_DSP1] + quot[17:0];

wire signed [18:0] fdif = scaled - filt;
wire        [18:0] fmag = fdif[18] ? -fdif : fdif;
wire        [2:0]  fsh  = {1'b0, prm[`MPI_P_FILT][1:0]} + 3'h1;
wire signed [18:0] fstp = fdif >>> fsh;
wire fbyp = (prm[`MPI_P_BAND] != 18'sh0) && (fmag > {1'b0, prm[`MPI_P_BAND]});

wire signed [17:0] reading = filt + prm[`MPI_P_OFS];

always @(posedge clk_sys or negedge rst_n)
begin
   if (!rst_n)
      filt <= 18'sh0;
   else if (meas_valid)
   begin
      if (prm[`MPI_P_FILT][1:0] == 2'h0 || fbyp)
         filt <= scaled;
      else
         filt <= filt + fstp[17:0];
   end
end

always @(posedge clk_sys or negedge rst_n)
begin
   if (!rst_n)
   begin
      sel_cnt  <= {CW{1'b0}};
      rst_cnt  <= {CW{1'b0}};
      alt_cnt  <= {CW{1'b0}};
      sel_long <= 1'b0;
      annun1   <= 1'b0;
      annun2   <= 1'b0;
   end
   else
   begin
      if (!deb[0])
         sel_cnt <= {CW{1'b0}};
      else if (!sel_long)
         sel_cnt <= sel_cnt + 1'b1;
      if (!deb[0])
         sel_long <= 1'b0;
      else if (sel_hold)
         sel_long <= 1'b1;
      if (!deb[1] || rst_rpt)
         rst_cnt <= {CW{1'b0}};
      else
         rst_cnt <= rst_cnt + 1'b1;
      alt_cnt <= (alt_cnt == ALT_CYC - 1) ? {CW{1'b0}} : alt_cnt + 1'b1;
      annun1 <= sp1_active;
      annun2 <= sp2_active;
   end
end

////////////////////////////////////////////////////////////////////////
// menu, user functions and register port

reg [3:0] np;
reg       do_rst;

always @*
begin
   np = par_idx + 4'h1;
   if (np == `MPI_P_SCRL && !scr_ok)
      np = `MPI_P_UFN;
   do_rst = pr_pend ||
            (rise[2] && ufn == `MPI_UF_RST) ||
            (rise[1] && menu_state == S_DISP);
end

always @(posedge clk_sys or negedge rst_n)
begin
   if (!rst_n)
   begin
      for (k = 0; k < `MPI_NPAR; k = k + 1)
         prm[k] <= 18'sh0;
      prm[`MPI_P_FILT] <= `MPI_RST_FILT;
      prm[`MPI_P_BAND] <= `MPI_RST_BAND;
      prm[`MPI_P_IN2]  <= `MPI_RST_IN2;
      prm[`MPI_P_DSP2] <= `MPI_RST_DSP2;
      ctrl        <= `MPI_RST_CTRL;
      min_cap     <= 18'sh0;
      max_cap     <= 18'sh0;
      disp_out    <= 18'sh0;
      disp_sel    <= `MPI_DS_INP;
      menu_state  <= S_DISP;
      mod_idx     <= 1'b0;
      par_idx     <= 4'h0;
      show_value  <= 1'b0;
      edit_digit  <= 3'h0;
      work_val    <= 18'sh0;
      work_bcd    <= 20'h0;
      work_neg    <= 1'b0;
      intensity   <= `MPI_MAX_INT;
      color_green <= 1'b0;
      nv_commit   <= 1'b0;
      print_req   <= 1'b0;
      sp1_reset   <= 1'b0;
      sp2_reset   <= 1'b0;
      pr_pend     <= 1'b0;
      scr_cnt     <= {CW{1'b0}};
      reg_rdata   <= 32'h0;
   end
   else
   begin
      nv_commit <= 1'b0;
      print_req <= 1'b0;
      sp1_reset <= 1'b0;
      sp2_reset <= 1'b0;
      pr_pend   <= 1'b0;
      if (alt_cnt == ALT_CYC - 1)
         show_value <= ~show_value;
      // register port
      if (reg_wr && reg_addr < `MPI_NPAR)
         prm[reg_addr] <= reg_wdata[17:0];
      if (reg_wr && reg_addr == `MPI_A_CTRL)
         ctrl <= reg_wdata;
      if (reg_rd)
         case (reg_addr)
            `MPI_A_CTRL: reg_rdata <= ctrl;
            `MPI_A_DISP: reg_rdata <= {{14{disp_out[17]}}, disp_out};
            `MPI_A_MIN:  reg_rdata <= {{14{min_cap[17]}}, min_cap};
            `MPI_A_MAX:  reg_rdata <= {{14{max_cap[17]}}, max_cap};
            `MPI_A_STAT: reg_rdata <= {20'h0, par_idx, mod_idx, menu_state, disp_sel, usr_on, locked};
            default:     reg_rdata <= (reg_addr < `MPI_NPAR) ?
                                      {{14{prm[reg_addr][17]}}, prm[reg_addr]} : 32'h0;
         endcase
      // hold freezes only the shown value
      if (!(ufn == `MPI_UF_HOLD && usr_on))
         case (disp_sel)
            `MPI_DS_MAX: disp_out <= max_cap;
            `MPI_DS_MIN: disp_out <= min_cap;
            default:     disp_out <= reading;
         endcase
      if (meas_valid && reading > max_cap)
         max_cap <= reading;
      if (meas_valid && reading < min_cap)
         min_cap <= reading;
      if (do_rst && (uasn[0] || ufn == `MPI_UF_NONE))
         min_cap <= reading;
      if (do_rst && (uasn[1] || ufn == `MPI_UF_NONE))
         max_cap <= reading;
      if (rise[2] && ufn == `MPI_UF_ZERO && disp_sel == `MPI_DS_INP)
         prm[`MPI_P_OFS] <= -filt;
      if (rise[2] && ufn == `MPI_UF_DSEL && menu_state == S_DISP)
         disp_sel <= next_disp(disp_sel, min_en, max_en);
      if (rise[2] && ufn == `MPI_UF_INTEN && intensity != `MPI_MAX_INT)
         intensity <= intensity + 3'h1;
      if (rise[2] && ufn == `MPI_UF_COLOR)
         color_green <= ~color_green;
      if (rise[2] && (ufn == `MPI_UF_PRINT || ufn == `MPI_UF_PRST))
         print_req <= 1'b1;
      if (rise[2] && ufn == `MPI_UF_PRST)
         pr_pend <= 1'b1;
      if (rise[2] && (ufn == `MPI_UF_SP1 || ufn == `MPI_UF_SP12))
         sp1_reset <= 1'b1;
      if (rise[2] && (ufn == `MPI_UF_SP2 || ufn == `MPI_UF_SP12))
         sp2_reset <= 1'b1;
      if (menu_state != S_DISP || !prm[`MPI_P_SCRL][0] || !scr_ok)
         scr_cnt <= {CW{1'b0}};
      else if (scr_cnt == SCRL_CYC - 1)
      begin
         scr_cnt  <= {CW{1'b0}};
         disp_sel <= next_disp(disp_sel, min_en, max_en);
      end
      else
         scr_cnt <= scr_cnt + 1'b1;
      case (menu_state)
         S_DISP:
         begin
            if (rise[0])
               disp_sel <= next_disp(disp_sel, min_en, max_en);
            if (sel_hold && !locked)
            begin
               menu_state <= S_MOD;
               mod_idx    <= 1'b1;
            end
         end
         S_MOD:
         begin
            if (rise[1])
               mod_idx <= ~mod_idx;
            if (rise[0] && mod_idx)
            begin
               menu_state <= S_PAR;
               par_idx    <= `MPI_P_FILT;
               work_val   <= prm[`MPI_P_FILT];
            end
            else if (rise[0])
            begin
               nv_commit  <= 1'b1;
               menu_state <= S_DISP;
            end
         end
         S_PAR:
         begin
            if (rise[0])
            begin
               prm[par_idx] <= work_val;
               par_idx      <= np;
               work_val     <= (np < `MPI_NPAR) ? prm[np] : 18'sh0;
               if (par_idx == `MPI_P_UASN)
                  menu_state <= S_MOD;
            end
            else if (rise[1] && prm[`MPI_P_STYLE][0] &&
                     (par_idx == `MPI_P_IN1 || par_idx == `MPI_P_IN2))
               menu_state <= S_LIVE;
            else if (rise[1] && is_num(par_idx))
            begin
               menu_state <= S_EDIT;
               edit_digit <= 3'h0;
               work_neg   <= work_val[17];
               work_bcd   <= to_bcd(work_val[17] ? -work_val[16:0] : work_val[16:0]);
            end
            else if (rise[1])
               work_val <= (work_val >= choice_max(par_idx)) ? 18'sh0 : work_val + 18'sh1;
         end
         S_EDIT:
         begin
            if (rise[1] || rst_rpt)
               work_bcd[edit_digit*4 +: 4] <= (work_bcd[edit_digit*4 +: 4] == 4'h9) ?
                                              4'h0 : work_bcd[edit_digit*4 +: 4] + 4'h1;
            if (fall[0] && !sel_long)
               edit_digit <= (edit_digit == `MPI_LAST_DIG) ? 3'h0 : edit_digit + 3'h1;
            if (sel_hold)
            begin
               prm[par_idx] <= work_neg ? -from_bcd(work_bcd) : from_bcd(work_bcd);
               par_idx      <= np;
               work_val     <= prm[np];
               menu_state   <= S_PAR;
            end
            else
               work_val <= work_neg ? -from_bcd(work_bcd) : from_bcd(work_bcd);
         end
         S_LIVE:
         begin
            if (rise[0])
            begin
               prm[par_idx] <= {2'h0, meas_in};
               par_idx      <= np;
               work_val     <= prm[np];
               menu_state   <= S_PAR;
            end
            else
               work_val <= {2'h0, meas_in};
         end
         default:
            menu_state <= S_DISP;
      endcase
   end
end

endmodule

/* rtl/mpi_regs.vh */
// constants for the meter panel input processing block
`ifndef MPI_REGS_VH
`define MPI_REGS_VH
// parameter indexes, also the register word addresses
`define MPI_NPAR      4'hB
`define MPI_P_FILT    4'h0
`define MPI_P_BAND    4'h1
`define MPI_P_OFS     4'h2
`define MPI_P_STYLE   4'h3
`define MPI_P_IN1     4'h4
`define MPI_P_DSP1    4'h5
`define MPI_P_IN2     4'h6
`define MPI_P_DSP2    4'h7
`define MPI_P_SCRL    4'h8
`define MPI_P_UFN     4'h9
`define MPI_P_UASN    4'hA
`define MPI_A_CTRL    4'hB
`define MPI_A_DISP    4'hC
`define MPI_A_MIN     4'hD
`define MPI_A_MAX     4'hE
`define MPI_A_STAT    4'hF
// control register fields
`define MPI_C_MINEN   0
`define MPI_C_MAXEN   1
`define MPI_C_SEC_LO  16
`define MPI_C_SEC_HI  25
// reset values
`define MPI_RST_FILT  18'h00001
`define MPI_RST_BAND  18'h0000A
`define MPI_RST_IN2   18'h0EA5F
`define MPI_RST_DSP2  18'h0EA5F
`define MPI_RST_CTRL  32'h00000003
// choice limits
`define MPI_MAX_FILT  18'h00003
`define MPI_MAX_BIN   18'h00001
`define MPI_MAX_UFN   18'h0000C
`define MPI_MAX_UASN  18'h00003
// user input functions
`define MPI_UF_NONE   4'h0
`define MPI_UF_PLOC   4'h1
`define MPI_UF_ZERO   4'h2
`define MPI_UF_RST    4'h3
`define MPI_UF_HOLD   4'h4
`define MPI_UF_DSEL   4'h5
`define MPI_UF_INTEN  4'h6
`define MPI_UF_COLOR  4'h7
`define MPI_UF_PRINT  4'h8
`define MPI_UF_PRST   4'h9
`define MPI_UF_SP1    4'hA
`define MPI_UF_SP2    4'hB
`define MPI_UF_SP12   4'hC
// shown values
`define MPI_DS_INP    2'h0
`define MPI_DS_MAX    2'h1
`define MPI_DS_MIN    2'h2
// edit digits and intensity
`define MPI_LAST_DIG  3'h4
`define MPI_MAX_INT   3'h5
// times in ms and the clock in kHz
`define MPI_CLK_KHZ   100000
`define MPI_DEB_MS    10
`define MPI_HOLD_MS   2000
`define MPI_RPT_MS    250
`define MPI_ALT_MS    1000
`define MPI_SCRL_MS   4000
`endif

/* bench/mpi_operator.sv */
// operator keys and user input contact model
`timescale 1ns/1ps
module mpi_operator (
   // clock
   input  wire  clk_sys,
   // keys and contact
   output logic key_sel,
   output logic key_rst,
   output logic usr_in_n
);
   // contact open: the pull-up keeps the line high
   initial
   begin
      key_sel = 1'b0;
      key_rst = 1'b0;
      usr_in_n = 1'b1;
   end
   // k: 0 select, 1 reset key, 2 contact; held n cycles, then idle long enough to settle
   task automatic act(input int k, input int n);
      @(posedge clk_sys);
      case (k)
         0: key_sel <= 1'b1;
         1: key_rst <= 1'b1;
         default: usr_in_n <= 1'b0;
      endcase
      repeat (n) @(posedge clk_sys);
      key_sel <= 1'b0;
      key_rst <= 1'b0;
      usr_in_n <= 1'b1;
      repeat (8) @(posedge clk_sys);
   endtask
endmodule

/* bench/mpi_top_asserts.sv */
// assertions on the ports of the panel meter block
`timescale 1ns/1ps
module mpi_top_asserts #(
   parameter HOLD_CYC = 20
)(
   // clock and reset
   input wire       clk_sys,
   input wire       rst_n,
   // inputs
   input wire       key_sel,
   input wire       sp1_active,
   input wire       sp2_active,
   // outputs
   input wire [1:0] disp_sel,
   input wire [2:0] menu_state,
   input wire       mod_idx,
   input wire [2:0] edit_digit,
   input wire       annun1,
   input wire       annun2,
   input wire [2:0] intensity,
   input wire       nv_commit,
   input wire       print_req
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);
   int sel_run;
   // run length of the raw select key
   always @(posedge clk_sys or negedge rst_n)
      if (!rst_n)
         sel_run <= 0;
      else
         sel_run <= key_sel ? sel_run + 1 : 0;
   sequence s_entered;
      $past(menu_state) == 3'h0 && menu_state == 3'h1;
   endsequence
   sequence s_opened;
      $past(menu_state) == 3'h2 && menu_state == 3'h3;
   endsequence
   a_annun_follow: assert property (annun1 == $past(sp1_active) && annun2 == $past(sp2_active))
      else $error("annunciator differs from setpoint state");
   a_entry_hold: assert property (s_entered |-> mod_idx && sel_run >= HOLD_CYC)
      else $error("program mode entered without a full hold");
   a_edit_open: assert property (s_opened |-> edit_digit == 3'h0)
      else $error("edit did not open at the rightmost digit");
   a_digit_step: assert property ((menu_state == 3'h3 && $past(menu_state) == 3'h3 && $changed(edit_digit))
      |-> edit_digit == (($past(edit_digit) == 3'h4) ? 3'h0 : $past(edit_digit) + 3'h1))
      else $error("edit digit moved wrongly");
   a_commit_exit: assert property (nv_commit |-> $past(menu_state) == 3'h1 && !$past(mod_idx)
      ##1 !nv_commit && menu_state == 3'h0)
      else $error("commit outside the exit prompt");
   a_disp_mode: assert property ($changed(disp_sel) |-> $past(menu_state) == 3'h0 && disp_sel != 2'h3)
      else $error("shown value changed outside display mode");
   a_menu_range: assert property (menu_state <= 3'h4)
      else $error("menu state out of range");
   a_level_range: assert property (intensity >= 3'h1 && intensity <= 3'h5)
      else $error("intensity out of range");
   a_print_pulse: assert property (print_req |=> !print_req)
      else $error("print request longer than one cycle");
endmodule
bind mpi_top mpi_top_asserts #(.HOLD_CYC(HOLD_CYC)) u_chk (
   .clk_sys(clk_sys), .rst_n(rst_n), .key_sel(key_sel), .sp1_active(sp1_active),
   .sp2_active(sp2_active), .disp_sel(disp_sel), .menu_state(menu_state), .mod_idx(mod_idx),
   .edit_digit(edit_digit), .annun1(annun1), .annun2(annun2), .intensity(intensity),
   .nv_commit(nv_commit), .print_req(print_req)
);

/* bench/test_meter_panel_input_processing.sv */
// self-checking bench of the panel meter block
`timescale 1ns/1ps
`include "mpi_regs.vh"
module test_meter_panel_input_processing;
   logic        clk_sys = 1'b0;
   logic        rst_n = 1'b0;
   logic        meas_valid = 1'b0;
   logic        sp1_active = 1'b0;
   logic        sp2_active = 1'b0;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic        rd_seen = 1'b0;
   logic        col_d = 1'b0;
   logic [15:0] meas_in = 16'h0000;
   logic [3:0]  reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h00000000;
   logic [19:0] evt = 20'h00000;
   logic [19:0] snap;
   logic [63:0] e;
   logic [63:0] exp_q[$];
   logic [31:0] rst_tab[12] = '{32'h1, 32'hA, 32'h0, 32'h0, 32'h0, 32'h0, 32'hEA5F, 32'hEA5F,
                                32'h0, 32'h0, 32'h0, 32'h3};
   logic [23:0] fx[7] = '{24'h500000, 24'h700001, 24'h810000, 24'h910000, 24'hA01000, 24'hB00100,
                          24'hC01100};
   int          mt[4][4] = '{'{0, 0, 50, 507}, '{1, 0, 90, 607}, '{1, 10, 10, 107}, '{0, 0, 200, 2007}};
   int          fail_count = 0;
   int          checks_done = 0;
   int          cyc = 0;
   int          v;
   int unsigned rnd;
   wire         key_sel, key_rst, usr_in_n, nv_commit, print_req, sp1_reset, sp2_reset, color_green;
   wire [31:0]  reg_rdata;

   always #5 clk_sys = ~clk_sys;

   mpi_top #(.DEB_CYC(2), .HOLD_CYC(20), .RPT_CYC(8), .ALT_CYC(16), .SCRL_CYC(30)) uut (
      .clk_sys(clk_sys), .rst_n(rst_n), .key_sel(key_sel), .key_rst(key_rst), .usr_in_n(usr_in_n),
      .meas_in(meas_in), .meas_valid(meas_valid), .sp1_active(sp1_active), .sp2_active(sp2_active),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .disp_out(), .disp_sel(), .menu_state(), .mod_idx(), .par_idx(),
      .show_value(), .edit_digit(), .work_val(), .annun1(), .annun2(), .intensity(),
      .color_green(color_green), .nv_commit(nv_commit), .print_req(print_req),
      .sp1_reset(sp1_reset), .sp2_reset(sp2_reset));

   mpi_operator op (.clk_sys(clk_sys), .key_sel(key_sel), .key_rst(key_rst), .usr_in_n(usr_in_n));

   task automatic check(input logic [31:0] seen, input logic [31:0] x);
      checks_done++;
      if (seen !== x)
      begin
         fail_count++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, x);
      end
   endtask

   task automatic complete_run();
      $display("checks %0d, mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask

   // notes the masked expectation, then strobes the read
   task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] x);
      exp_q.push_back({m, x & m});
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
   endtask

   task automatic st(input logic [31:0] m, input logic [31:0] x);
      rd(`MPI_A_STAT, m, x);
   endtask

   // read data stand from the cycle after the strobe until the next read; event counts per nibble
   always @(posedge clk_sys)
   begin
      if (rd_seen)
      begin
         e = exp_q.pop_front();
         check(reg_rdata & e[63:32], e[31:0]);
      end
      rd_seen <= reg_rd;
      sp1_active <= rst_n & 1'($urandom);
      sp2_active <= rst_n & 1'($urandom);
      col_d <= color_green;
      if (rst_n)
         evt <= evt + {3'h0, print_req, 3'h0, sp1_reset, 3'h0, sp2_reset, 3'h0, nv_commit, 3'h0, color_green ^ col_d};
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         fail_count++;
         complete_run();
      end
   end

   initial
   begin
      rnd = $urandom(1234);
      repeat (10) @(posedge clk_sys);
      rst_n <= 1'b1;
      for (int a = 0; a < 12; a++)
         rd(4'(a), 32'hFFFFFFFF, rst_tab[a]);
      wr(`MPI_A_STAT, 32'hFFFFFFFF);
      wr(`MPI_A_DISP, 32'h0001FFFF);
      st(32'h000000FF, 32'h00000000);
      rd(`MPI_A_DISP, 32'h0003FFFF, 32'h00000000);
      repeat (4)
      begin
         v = int'($urandom_range(39998)) - 19999;
         wr(`MPI_P_OFS, 32'(v));
         rd(`MPI_P_OFS, 32'hFFFFFFFF, 32'(v));
      end
      wr(`MPI_P_OFS, 32'h00000007);
      wr(`MPI_P_IN2, 32'h00000064);
      wr(`MPI_P_DSP2, 32'h000003E8);
      for (int i = 0; i < 4; i++)
      begin
         wr(`MPI_P_FILT, 32'(mt[i][0]));
         wr(`MPI_P_BAND, 32'(mt[i][1]));
         @(posedge clk_sys);
         meas_in <= 16'(mt[i][2]);
         meas_valid <= 1'b1;
         @(posedge clk_sys);
         meas_valid <= 1'b0;
         repeat (3) @(posedge clk_sys);
         rd(`MPI_A_DISP, 32'h0003FFFF, 32'(mt[i][3]));
      end
      wr(`MPI_P_UFN, {28'h0, `MPI_UF_HOLD});
      meas_in <= 16'h012C;
      fork
         op.act(2, 30);
         begin
            repeat (12) @(posedge clk_sys);
            meas_valid <= 1'b1;
            @(posedge clk_sys);
            meas_valid <= 1'b0;
            rd(`MPI_A_DISP, 32'h0003FFFF, 32'h000007D7);
         end
      join
      rd(`MPI_A_DISP, 32'h0003FFFF, 32'h00000BBF);
      wr(`MPI_P_UFN, {28'h0, `MPI_UF_RST});
      wr(`MPI_P_UASN, 32'h00000003);
      op.act(2, 6);
      rd(`MPI_A_MIN, 32'h0003FFFF, 32'h00000BBF);
      rd(`MPI_A_MAX, 32'h0003FFFF, 32'h00000BBF);
      for (int i = 0; i < 7; i++)
      begin
         wr(`MPI_P_UFN, {28'h0, fx[i][23:20]});
         snap = evt;
         op.act(2, 6);
         check(evt - snap, fx[i][19:0]);
      end
      wr(`MPI_P_UFN, {28'h0, `MPI_UF_NONE});
      st(32'h0000000C, 32'h00000004);
      wr(`MPI_P_SCRL, 32'h00000001);
      repeat (30) @(posedge clk_sys);
      st(32'h0000000C, 32'h00000008);
      wr(`MPI_P_SCRL, 32'h00000000);
      op.act(0, 6);
      st(32'h0000000C, 32'h00000000);
      op.act(0, 6);
      st(32'h0000000C, 32'h00000004);
      wr(`MPI_A_CTRL, 32'h00010003);
      op.act(0, 30);
      st(32'h00000071, 32'h00000001);
      wr(`MPI_A_CTRL, 32'h00000003);
      op.act(0, 30);
      st(32'h000000F0, 32'h00000090);
      op.act(1, 6);
      st(32'h000000F0, 32'h00000010);
      op.act(1, 6);
      op.act(0, 6);
      st(32'h00000F70, 32'h00000020);
      op.act(1, 6);
      op.act(0, 6);
      rd(`MPI_P_FILT, 32'hFFFFFFFF, 32'h00000001);
      st(32'h00000F70, 32'h00000120);
      op.act(1, 6);
      st(32'h00000070, 32'h00000030);
      op.act(1, 6);
      op.act(0, 6);
      op.act(1, 6);
      op.act(0, 30);
      rd(`MPI_P_BAND, 32'hFFFFFFFF, 32'h0000000B);
      st(32'h00000F70, 32'h00000220);
      repeat (9) op.act(0, 6);
      st(32'h00000070, 32'h00000010);
      op.act(1, 6);
      snap = evt;
      op.act(0, 6);
      check(evt - snap, 32'h00000010);
      st(32'h00000070, 32'h00000000);
      rd(`MPI_P_BAND, 32'hFFFFFFFF, 32'h0000000B);
      wr(`MPI_P_UFN, {28'h0, `MPI_UF_ZERO});
      op.act(2, 6);
      rd(`MPI_A_DISP, 32'h0003FFFF, 32'h00000000);
      rd(`MPI_P_OFS, 32'hFFFFFFFF, 32'hFFFFF448);
      repeat (5) @(posedge clk_sys);
      complete_run();
   end
endmodule
